// ===== hw/upir_pkg.sv
package upir_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int UPIR_AW = 6;
  localparam int UPIR_DW = 8;
  localparam int UPIR_NSRC = 5;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] UPIR_RISE_WR = 6'h0D;
  localparam logic [5:0] UPIR_RISE_SET = 6'h0E;
  localparam logic [5:0] UPIR_RISE_CLR = 6'h0F;
  localparam logic [5:0] UPIR_FALL_WR = 6'h10;
  localparam logic [5:0] UPIR_FALL_SET = 6'h11;
  localparam logic [5:0] UPIR_FALL_CLR = 6'h12;
  localparam logic [5:0] UPIR_LIVE = 6'h13;
  localparam logic [5:0] UPIR_LATCH = 6'h14;
  localparam logic [5:0] UPIR_MIRROR = 6'h15;
  localparam logic [5:0] UPIR_SPARE_WR = 6'h16;
  localparam logic [5:0] UPIR_SPARE_SET = 6'h17;
  localparam logic [5:0] UPIR_SPARE_CLR = 6'h18;
  localparam logic [5:0] UPIR_IRQ_STAT = 6'h30;
  localparam logic [5:0] UPIR_IRQ_MASK = 6'h31;

  // ---------------------------------------------------------------
  // source bit positions, shared by every event register
  // ---------------------------------------------------------------
  localparam int UPIR_SRC_HOSTDISC = 0;
  localparam int UPIR_SRC_VBUS = 1;
  localparam int UPIR_SRC_SESS_OK = 2;
  localparam int UPIR_SRC_SESS_OVER = 3;
  localparam int UPIR_SRC_ID_GND = 4;
  localparam int UPIR_LINE_LO = 0;
  localparam int UPIR_LINE_HI = 1;

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [4:0] UPIR_EN_RESET = 5'h1F;
  localparam logic [7:0] UPIR_SPARE_RESET = 8'h00;
  localparam logic [4:0] UPIR_MASK_RESET = 5'h00;
  localparam logic [1:0] UPIR_PRIME_CYCLES = 2'h3;

  // ---------------------------------------------------------------
  // register port request
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [UPIR_AW-1:0] addr;
    logic [UPIR_DW-1:0] wdata;
    logic wr;
    logic rd;
  } upir_req_s;

  // replace, set or clear a register held at three consecutive offsets
  function automatic logic [7:0] upir_wsc(
    input logic [7:0] cur,
    input logic [7:0] wdata,
    input logic [5:0] base,
    input logic [5:0] addr,
    input logic wr
  );
    logic [7:0] res;
    res = cur;
    if (wr && addr == base) begin
      res = wdata;
    end else if (wr && addr == base + 6'h01) begin
      res = cur | wdata;
    end else if (wr && addr == base + 6'h02) begin
      res = cur & ~wdata;
    end
    return res;
  endfunction : upir_wsc

endpackage : upir_pkg

// ===== hw/upir_edge_detect.sv
`timescale 1ns/1ns
module upir_edge_detect import upir_pkg::*; (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // raw comparator levels
  input wire logic [UPIR_NSRC-1:0] src_in,
  // synchronised levels and one-cycle edges
  output logic [UPIR_NSRC-1:0] level_out,
  output logic [UPIR_NSRC-1:0] rise_out,
  output logic [UPIR_NSRC-1:0] fall_out
);

  logic [UPIR_NSRC-1:0] meta_reg, meta_next;
  logic [UPIR_NSRC-1:0] sync_reg, sync_next;
  logic [UPIR_NSRC-1:0] prev_reg, prev_next;
  logic [UPIR_NSRC-1:0] rise_reg, rise_next;
  logic [UPIR_NSRC-1:0] fall_reg, fall_next;
  logic [1:0] prime_reg, prime_next;
  logic primed;

  // ---------------------------------------------------------------
  // edge detection
  // ---------------------------------------------------------------
  // edges are held off until the chain is filled, so the flops leaving
  // reset at zero never fake a rise on a source that is already high
  assign primed = (prime_reg == UPIR_PRIME_CYCLES);

  always_comb begin
    meta_next = src_in;
    sync_next = meta_reg; // first stage read only here
    prev_next = sync_reg;
    prime_next = primed ? prime_reg : prime_reg + 2'h1;
    rise_next = '0;
    fall_next = '0;
    for (int i = 0; i < UPIR_NSRC; i++) begin
      rise_next[i] = primed && sync_reg[i] && !prev_reg[i];
      fall_next[i] = primed && !sync_reg[i] && prev_reg[i];
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
      rise_reg <= '0;
      fall_reg <= '0;
      prime_reg <= 2'h0;
    end else begin
      meta_reg <= meta_next;
      sync_reg <= sync_next;
      prev_reg <= prev_next;
      rise_reg <= rise_next;
      fall_reg <= fall_next;
      prime_reg <= prime_next;
    end
  end

  // levels follow the comparators, never a constant
  assign level_out = prev_reg;
  assign rise_out = rise_reg;
  assign fall_out = fall_reg;

endmodule : upir_edge_detect

// ===== hw/upir_regs.sv
// The strobed register port was left to the implementer.
`timescale 1ns/1ns
module upir_regs import upir_pkg::*; (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // register port
  input wire upir_req_s bus_req_in,
  output logic [UPIR_DW-1:0] rdata_out,
  // comparator levels and line state
  input wire logic [UPIR_NSRC-1:0] src_level_in,
  input wire logic [1:0] line_level_in,
  input wire logic host_mode_in,
  // notification to the link
  output logic irq_out
);

  logic [UPIR_NSRC-1:0] live;
  logic [UPIR_NSRC-1:0] rise_e;
  logic [UPIR_NSRC-1:0] fall_e;
  logic [UPIR_NSRC-1:0] src_ok;
  logic [UPIR_NSRC-1:0] ev;

  logic [4:0] rise_en_reg, rise_en_next;
  logic [4:0] fall_en_reg, fall_en_next;
  logic [4:0] latch_reg, latch_next;
  logic [7:0] spare_reg, spare_next;
  logic [4:0] irq_stat_reg, irq_stat_next;
  logic [4:0] irq_mask_reg, irq_mask_next;
  logic [1:0] line_reg, line_next;
  logic [7:0] rdata_reg, rdata_next;
  logic irq_reg, irq_next;

  logic [7:0] rise_w, fall_w, spare_w;
  logic wr, rd;
  logic [5:0] addr;
  logic [7:0] wdata;

  // ---------------------------------------------------------------
  // source synchronisation and edges
  // ---------------------------------------------------------------
  upir_edge_detect u_edge (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .src_in(src_level_in),
    .level_out(live),
    .rise_out(rise_e),
    .fall_out(fall_e)
  );

  // host disconnect only carries meaning as a host
  always_comb begin
    src_ok = '1;
    src_ok[UPIR_SRC_HOSTDISC] = host_mode_in;
  end

  // an edge is an event only if its direction is enabled
  assign ev = ((rise_e & rise_en_reg) | (fall_e & fall_en_reg)) & src_ok;

  // ---------------------------------------------------------------
  // register port decode
  // ---------------------------------------------------------------
  assign wr = bus_req_in.wr;
  assign rd = bus_req_in.rd;
  assign addr = bus_req_in.addr;
  assign wdata = bus_req_in.wdata;

  // write, set and clear views of the three triplet registers
  assign rise_w = upir_wsc({3'h0, rise_en_reg}, wdata, UPIR_RISE_WR,
                           addr, wr);
  assign fall_w = upir_wsc({3'h0, fall_en_reg}, wdata, UPIR_FALL_WR,
                           addr, wr);
  assign spare_w = upir_wsc(spare_reg, wdata, UPIR_SPARE_WR, addr, wr);

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  // latch has no write path; a read clears it, a same-cycle event
  // still lands so nothing is lost between read and clear
  always_comb begin
    rise_en_next = rise_w[4:0];
    fall_en_next = fall_w[4:0];
    spare_next = spare_w;
    latch_next = latch_reg;
    if (rd && addr == UPIR_LATCH) begin
      latch_next = '0;
    end
    latch_next = latch_next | ev;
    irq_stat_next = irq_stat_reg;
    if (wr && addr == UPIR_IRQ_STAT) begin
      irq_stat_next = irq_stat_reg & ~wdata[4:0];
    end
    irq_stat_next = irq_stat_next | ev;
    irq_mask_next = irq_mask_reg;
    if (wr && addr == UPIR_IRQ_MASK) begin
      irq_mask_next = wdata[4:0];
    end
    line_next = line_level_in;
    irq_next = |(irq_stat_next & irq_mask_next);
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  // data stand only in the cycle after the strobe, zero otherwise
  always_comb begin
    rdata_next = 8'h00;
    if (rd) begin
      case (addr)
        UPIR_RISE_WR, UPIR_RISE_SET, UPIR_RISE_CLR: begin
          rdata_next = {3'h0, rise_en_reg};
        end
        UPIR_FALL_WR, UPIR_FALL_SET, UPIR_FALL_CLR: begin
          rdata_next = {3'h0, fall_en_reg};
        end
        UPIR_LIVE: begin
          rdata_next = {3'h0, live & src_ok};
        end
        UPIR_LATCH: begin
          rdata_next = {3'h0, latch_reg};
        end
        UPIR_MIRROR: begin
          rdata_next = {6'h00, line_reg};
        end
        UPIR_SPARE_WR, UPIR_SPARE_SET, UPIR_SPARE_CLR: begin
          rdata_next = spare_reg;
        end
        UPIR_IRQ_STAT: begin
          rdata_next = {3'h0, irq_stat_reg};
        end
        UPIR_IRQ_MASK: begin
          rdata_next = {3'h0, irq_mask_reg};
        end
        default: begin
          rdata_next = 8'h00;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rise_en_reg <= UPIR_EN_RESET;
      fall_en_reg <= UPIR_EN_RESET;
      latch_reg <= '0;
      spare_reg <= UPIR_SPARE_RESET;
      irq_stat_reg <= '0;
      irq_mask_reg <= UPIR_MASK_RESET;
      line_reg <= 2'h0;
      rdata_reg <= 8'h00;
      irq_reg <= 1'b0;
    end else begin
      rise_en_reg <= rise_en_next;
      fall_en_reg <= fall_en_next;
      latch_reg <= latch_next;
      spare_reg <= spare_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      line_reg <= line_next;
      rdata_reg <= rdata_next;
      irq_reg <= irq_next;
    end
  end

  assign rdata_out = rdata_reg;
  assign irq_out = irq_reg;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  sequence s_latch_read;
    rd && addr == UPIR_LATCH && ev == '0;
  endsequence

  sequence s_latch_empty;
    latch_reg == '0;
  endsequence

  a_latch_read_clear: assert property (
    s_latch_read |=> s_latch_empty and rdata_out == {3'h0, $past(latch_reg)})
    else $error("latch not cleared by read");

  a_latch_event_set: assert property (
    ev != '0 |=> (latch_reg & $past(ev)) == $past(ev))
    else $error("enabled edge did not set latch");

  a_rise_to_latch: assert property (
    rise_e[UPIR_SRC_VBUS] && rise_en_reg[UPIR_SRC_VBUS]
      |=> latch_reg[UPIR_SRC_VBUS] && irq_stat_reg[UPIR_SRC_VBUS])
    else $error("enabled rise lost");

  a_fall_to_latch: assert property (
    fall_e[UPIR_SRC_ID_GND] && fall_en_reg[UPIR_SRC_ID_GND]
      |=> latch_reg[UPIR_SRC_ID_GND])
    else $error("enabled fall lost");

  a_host_disc_gate: assert property (
    !host_mode_in && latch_reg[UPIR_SRC_HOSTDISC] == 1'b0
      && !(rd && addr == UPIR_LATCH) |=> !latch_reg[UPIR_SRC_HOSTDISC])
    else $error("host disconnect flagged outside host mode");

  a_live_read: assert property (
    rd && addr == UPIR_LIVE
      |=> rdata_out[7:5] == 3'h0
          && rdata_out[4:1] == $past(live[4:1]))
    else $error("live register mismatch");

  a_mirror_read: assert property (
    rd && addr == UPIR_MIRROR ##1 1'b1
      |=> rdata_out == 8'h00 || $past(rd, 1))
    else $error("read data held too long");

  a_mirror_bits: assert property (
    rd && addr == UPIR_MIRROR |=> rdata_out == {6'h00, $past(line_reg)})
    else $error("mirror register mismatch");

  a_enable_clear: assert property (
    wr && addr == UPIR_RISE_CLR
      |=> rise_en_reg == ($past(rise_en_reg) & ~$past(wdata[4:0])))
    else $error("enable clear wrong");

  a_spare_set: assert property (
    wr && addr == UPIR_SPARE_SET
      |=> spare_reg == ($past(spare_reg) | $past(wdata)))
    else $error("spare set wrong");

  a_spare_hold: assert property (
    !(wr && addr >= UPIR_SPARE_WR && addr <= UPIR_SPARE_CLR)
      |=> $stable(spare_reg))
    else $error("spare byte changed without write");

  a_irq_level: assert property (
    irq_out == |(irq_stat_reg & irq_mask_reg))
    else $error("interrupt output disagrees with status");

  a_rise_write: assert property (
    wr && addr == UPIR_RISE_WR
      |=> rise_en_reg == $past(wdata[4:0]))
    else $error("enable write wrong");

  a_fall_set: assert property (
    wr && addr == UPIR_FALL_SET
      |=> fall_en_reg == ($past(fall_en_reg) | $past(wdata[4:0])))
    else $error("enable set wrong");

  a_fall_clear: assert property (
    wr && addr == UPIR_FALL_CLR
      |=> fall_en_reg == ($past(fall_en_reg) & ~$past(wdata[4:0])))
    else $error("fall enable clear wrong");

  sequence s_rise_read;
    rd && addr >= UPIR_RISE_WR && addr <= UPIR_RISE_CLR;
  endsequence

  a_enable_read: assert property (
    s_rise_read |=> rdata_out == {3'h0, $past(rise_en_reg)})
    else $error("enable read back wrong");

  a_spare_write: assert property (
    wr && addr == UPIR_SPARE_WR |=> spare_reg == $past(wdata))
    else $error("spare write wrong");

  a_spare_clear: assert property (
    wr && addr == UPIR_SPARE_CLR
      |=> spare_reg == ($past(spare_reg) & ~$past(wdata)))
    else $error("spare clear wrong");

  a_spare_read: assert property (
    rd && addr >= UPIR_SPARE_WR && addr <= UPIR_SPARE_CLR
      |=> rdata_out == $past(spare_reg))
    else $error("spare read back wrong");

  // no read and no event: the latch must not move, whatever is written
  a_latch_hold: assert property (
    !(rd && addr == UPIR_LATCH) && ev == '0 |=> $stable(latch_reg))
    else $error("latch changed without read or event");

  a_irq_clear: assert property (
    wr && addr == UPIR_IRQ_STAT && ev == '0
      |=> irq_stat_reg == ($past(irq_stat_reg) & ~$past(wdata[4:0])))
    else $error("interrupt status clear wrong");

  a_host_live_mask: assert property (
    !host_mode_in && rd && addr == UPIR_LIVE |=> rdata_out[0] == 1'b0)
    else $error("host disconnect level shown outside host mode");

endmodule : upir_regs

// ===== verif/upir_link_model.sv
`timescale 1ns/1ns
// ---------------------------------------------------------------
// link side of the register port
// ---------------------------------------------------------------
module upir_link_model import upir_pkg::*; (
  // clock
  input wire logic ref_clk_in,
  // register port toward the device
  output upir_req_s bus_req_out,
  input wire logic [UPIR_DW-1:0] rdata_in
);
  // idle bus from time zero
  initial begin
    bus_req_out = '0;
  end

  // one-cycle write; released bus shows inverted values, never stale
  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    bus_req_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk_in);
    bus_req_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask : reg_write

  // one-cycle read; data stand only in the cycle after the strobe
  task automatic reg_read(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk_in);
    bus_req_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk_in);
    bus_req_out <= '{addr: ~a, wdata: 8'hFF, wr: 1'b0, rd: 1'b0};
    @(negedge ref_clk_in);
    d = rdata_in;
  endtask : reg_read
endmodule : upir_link_model

// ===== verif/usb_phy_interrupt_regs_tb.sv
`timescale 1ns/1ns
module usb_phy_interrupt_regs_tb import upir_pkg::*; ;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic ref_clk_in;
  logic rst_n_in;
  upir_req_s bus_req;
  logic [7:0] rdata;
  logic [4:0] src;
  logic [1:0] line;
  logic host;
  logic irq;
  int err_total;
  int comparisons;
  logic [5:0] bases [3];

  upir_regs upir_regs_i (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req),
    .rdata_out(rdata), .src_level_in(src), .line_level_in(line),
    .host_mode_in(host), .irq_out(irq)
  );
  upir_link_model upir_link_model_i (
    .ref_clk_in(ref_clk_in), .bus_req_out(bus_req), .rdata_in(rdata)
  );

  // 125 MHz
  initial ref_clk_in = 1'b0;
  always #4 ref_clk_in = ~ref_clk_in;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    logic [7:0] d;
    upir_link_model_i.reg_read(a, d);
    chk(d, exp);
  endtask : rd_chk

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    upir_link_model_i.reg_write(a, d);
  endtask : wr

  // levels change, then enough cycles for sync, compare and latch
  task automatic drive_src(input logic [4:0] v);
    @(posedge ref_clk_in);
    src <= v;
    repeat (6) @(posedge ref_clk_in);
  endtask : drive_src

  // look at the level once the taking edge has settled
  task automatic irq_is(input logic e);
    @(negedge ref_clk_in);
    chk({7'h00, irq}, {7'h00, e});
  endtask : irq_is

  task automatic summarize;
    $display("err_total=%0d comparisons=%0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // hang guard, well beyond the sequence length
  initial begin
    #200000;
    err_total++;
    summarize();
  end

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  initial begin
    err_total = 0;
    comparisons = 0;
    bases = '{UPIR_RISE_WR, UPIR_FALL_WR, UPIR_SPARE_WR};
    src = 5'h0A;
    line = 2'h0;
    host = 1'b1;
    rst_n_in = 1'b0;
    repeat (12) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    repeat (6) @(posedge ref_clk_in);
    // values after reset, no fake events from reset zeros
    for (int i = 0; i < 6; i++) begin
      rd_chk(6'(UPIR_RISE_WR + i), {3'h0, UPIR_EN_RESET});
    end
    rd_chk(UPIR_SPARE_WR, UPIR_SPARE_RESET);
    rd_chk(UPIR_LATCH, 8'h00);
    rd_chk(UPIR_LIVE, 8'h0A);
    rd_chk(6'h20, 8'h00);
    rd_chk(UPIR_IRQ_MASK, 8'h00);
    irq_is(1'b0);
    // line mirror follows both bits, ignores writes
    for (int i = 0; i < 4; i++) begin
      @(posedge ref_clk_in);
      line <= 2'(i);
      wr(UPIR_MIRROR, 8'hFF);
      repeat (4) @(posedge ref_clk_in);
      rd_chk(UPIR_MIRROR, 8'(i));
    end
    // replace, set and clear, read back at all three offsets
    for (int k = 0; k < 3; k++) begin
      wr(bases[k], 8'h00);
      rd_chk(bases[k], 8'h00);
      wr(6'(bases[k] + 1), 8'h05);
      rd_chk(6'(bases[k] + 1), 8'h05);
      wr(6'(bases[k] + 2), 8'h01);
      rd_chk(6'(bases[k] + 2), 8'h04);
      wr(bases[k], 8'hFF);
      rd_chk(bases[k], (k == 2) ? 8'hFF : 8'h1F);
    end
    wr(UPIR_LIVE, 8'hFF);
    rd_chk(UPIR_LIVE, 8'h0A);
    // edges gated by enables; latch clears on read
    wr(UPIR_IRQ_MASK, 8'h1F);
    wr(UPIR_RISE_WR, 8'h04);
    wr(UPIR_FALL_WR, 8'h08);
    drive_src(5'h0E);
    irq_is(1'b1);
    rd_chk(UPIR_LATCH, 8'h04);
    rd_chk(UPIR_LATCH, 8'h00);
    irq_is(1'b1);
    wr(UPIR_IRQ_STAT, 8'h04);
    irq_is(1'b0);
    drive_src(5'h06);
    rd_chk(UPIR_LATCH, 8'h08);
    drive_src(5'h02);
    rd_chk(UPIR_LATCH, 8'h00);
    // host disconnect only counts in host mode
    wr(UPIR_RISE_SET, 8'h1F);
    wr(UPIR_FALL_SET, 8'h1F);
    @(posedge ref_clk_in);
    host <= 1'b0;
    drive_src(5'h03);
    rd_chk(UPIR_LATCH, 8'h00);
    rd_chk(UPIR_LIVE, 8'h02);
    drive_src(5'h02);
    rd_chk(UPIR_LATCH, 8'h00);
    @(posedge ref_clk_in);
    host <= 1'b1;
    drive_src(5'h03);
    rd_chk(UPIR_LATCH, 8'h01);
    drive_src(5'h02);
    rd_chk(UPIR_LATCH, 8'h01);
    // latch ignores writes
    drive_src(5'h00);
    wr(UPIR_LATCH, 8'h00);
    rd_chk(UPIR_LATCH, 8'h02);
    // masked event keeps status but not the interrupt
    wr(UPIR_IRQ_STAT, 8'hFF);
    irq_is(1'b0);
    wr(UPIR_IRQ_MASK, 8'h00);
    drive_src(5'h10);
    irq_is(1'b0);
    rd_chk(UPIR_IRQ_STAT, 8'h10);
    wr(UPIR_IRQ_MASK, 8'h10);
    irq_is(1'b1);
    wr(UPIR_IRQ_STAT, 8'h10);
    irq_is(1'b0);
    summarize();
  end
endmodule : usb_phy_interrupt_regs_tb
